//--- core/cfm_pkg.sv
// shared constants and types for the cooling-unit fault and alarm monitor
// assumes a 50 MHz system clock and externally digitized sensor readings
`default_nettype none
package cfm_pkg;

  // ---------------------------------------------------------------
  // clock and timebase
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 50_000_000;
  localparam int TICK_MS         = 1000;
  localparam int TICK_CYCLES     = TICK_MS * (CLK_HZ / 1000);
  localparam int BEEP_MS         = 300;
  localparam int BEEP_CYCLES     = BEEP_MS * (CLK_HZ / 1000);
  localparam int PAUSE_MS        = 2000;
  localparam int PAUSE_CYCLES    = PAUSE_MS * (CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // supervision timing, in timebase ticks (seconds)
  // ---------------------------------------------------------------
  localparam int FLOAT_SEC       = 60;
  localparam int STARTUP_MIN     = 20;
  localparam int STARTUP_SEC     = STARTUP_MIN * 60;
  localparam int LOWDIFF_SEC     = 60;
  localparam int LOWDIFF_HITS    = 3;

  // ---------------------------------------------------------------
  // sensor thresholds
  // ---------------------------------------------------------------
  localparam int RES_W           = 16;
  localparam int TEMP_W          = 8;
  // resistance in units of 100 ohm: 136.5 kohm and 566 kohm
  localparam logic [RES_W-1:0]  RES_LOW_LIM  = 16'h0555;
  localparam logic [RES_W-1:0]  RES_HIGH_LIM = 16'h161C;
  localparam logic signed [TEMP_W:0] MIN_DIFF_C = 9'sh005;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CFM_ALM_NONE    = 2'b00,
    CFM_ALM_SENSOR  = 2'b01,
    CFM_ALM_OVERFLOW = 2'b10,
    CFM_ALM_COOLING = 2'b11
  } cfm_alarm_t;

  typedef struct packed {
    logic [RES_W-1:0]         room_res;
    logic [RES_W-1:0]         coil_res;
    logic [RES_W-1:0]         outdoor_temp_sensor;
    logic signed [TEMP_W-1:0] room_temp;
    logic signed [TEMP_W-1:0] coil_temp;
  } cfm_sense_t;

  typedef struct packed {
    logic cool_req;
    logic fan_req;
    logic float_closed;
    logic buzzer_config_switch;
  } cfm_ctrl_t;

endpackage : cfm_pkg
`default_nettype wire

//--- core/cfm_buzzer.sv
// audible alarm pattern generator: n short beeps then a long pause, repeating
// assumes the alarm code is stable once raised
`timescale 1ns/1ns
`default_nettype none
module cfm_buzzer
  import cfm_pkg::*;
#(
  parameter int BEEP_LEN  = BEEP_CYCLES,
  parameter int PAUSE_LEN = PAUSE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire cfm_alarm_t alarm,
  input  wire logic       sound_en,
  output logic            buzzer
);

  typedef enum logic [1:0] {
    CFM_BZ_IDLE  = 2'b00,
    CFM_BZ_BEEP  = 2'b01,
    CFM_BZ_SPACE = 2'b10,
    CFM_BZ_PAUSE = 2'b11
  } cfm_bz_state_t;

  cfm_bz_state_t state_reg,  state_next;
  logic [31:0]   cnt_reg,    cnt_next;
  logic [1:0]    beeps_reg,  beeps_next;
  logic          buzzer_reg, buzzer_next;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg + 32'h1;
    beeps_next  = beeps_reg;
    buzzer_next = 1'b0;
    unique case (state_reg)
      CFM_BZ_IDLE: begin
        cnt_next = 32'h0;
        if (alarm != CFM_ALM_NONE && sound_en) begin
          state_next  = CFM_BZ_BEEP;
          beeps_next  = 2'h1;
          buzzer_next = 1'b1;
        end
      end
      CFM_BZ_BEEP: begin
        buzzer_next = 1'b1;
        if (cnt_reg == 32'(BEEP_LEN - 1)) begin
          state_next  = CFM_BZ_SPACE;
          cnt_next    = 32'h0;
          buzzer_next = 1'b0;
        end
      end
      CFM_BZ_SPACE: begin
        if (cnt_reg == 32'(BEEP_LEN - 1)) begin
          cnt_next = 32'h0;
          if (beeps_reg == alarm) begin
            state_next = CFM_BZ_PAUSE;
          end else begin
            state_next  = CFM_BZ_BEEP;
            beeps_next  = beeps_reg + 2'h1;
            buzzer_next = 1'b1;
          end
        end
      end
      CFM_BZ_PAUSE: begin
        if (cnt_reg == 32'(PAUSE_LEN - 1)) begin
          state_next = CFM_BZ_IDLE;
          cnt_next   = 32'h0;
        end
      end
    endcase
    // the switch only silences the sound; the alarm stays latched upstream
    if (!sound_en) begin
      state_next  = CFM_BZ_IDLE;
      buzzer_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= CFM_BZ_IDLE;
      cnt_reg    <= 32'h0;
      beeps_reg  <= 2'h0;
      buzzer_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      beeps_reg  <= beeps_next;
      buzzer_reg <= buzzer_next;
    end
  end

  assign buzzer = buzzer_reg;

endmodule : cfm_buzzer
`default_nettype wire

//--- core/cfm_monitor.sv
// fault supervision and alarm latch for a ceiling-mounted cooling unit controller
// assumes sensor values come digitized and synchronous to clk; power-on reset on rst_b
//
// How it works
// R1: drain pump output equals compressor output, every cycle.
// R2: float switch is normally closed; open means full pan, halt operation.
// R3: float open continuously 60 s raises overflow alarm, pattern 2.
// R4: any sensor below 136.5 kohm or above 566 kohm raises pattern 1.
// R5: after 20 min running, third low-difference minute raises cooling alarm, pattern 3.
// R6: any alarm stops the system and sounds its identifying pattern.
// R7: warning relay closed while any alarm active, open otherwise.
// R8: alarms stay latched until power is cycled; nothing else clears them.
// R9: configuration switch 4 off silences the buzzer; detection continues.
// R10: after power returns the unit resumes by itself, no operator action.
// R11: compressor runs only while cooling and fan requests are both active.
// R12: sensors arrive digitized and are sampled once per timebase tick.
`timescale 1ns/1ns
`default_nettype none
module cfm_monitor
  import cfm_pkg::*;
#(
  parameter int TICK_LEN  = TICK_CYCLES,
  parameter int BEEP_LEN  = BEEP_CYCLES,
  parameter int PAUSE_LEN = PAUSE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire cfm_ctrl_t  ctrl,
  input  wire cfm_sense_t sense,
  output logic            compressor_on,
  output logic            drain_pump_on,
  output logic            fan_on,
  output logic            warn_relay,
  output logic            buzzer,
  output cfm_alarm_t      alarm_code
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic res_bad(input logic [RES_W-1:0] r);
    res_bad = (r < RES_LOW_LIM) || (r > RES_HIGH_LIM);
  endfunction : res_bad

  // ---------------------------------------------------------------
  // one-second timebase
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic        tick_reg,     tick_next;

  always_comb begin
    tick_cnt_next = tick_cnt_reg + 32'h1;
    tick_next     = 1'b0;
    if (tick_cnt_reg == 32'(TICK_LEN - 1)) begin
      tick_cnt_next = 32'h0;
      tick_next     = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // ---------------------------------------------------------------
  // tick-sampled inputs
  // ---------------------------------------------------------------
  // sampling on the tick keeps every duration check aligned to whole seconds
  logic                     float_open_reg, float_open_next;
  logic                     sens_bad_reg,   sens_bad_next;
  logic                     low_diff_reg,   low_diff_next;
  logic signed [TEMP_W:0]   diff_c;

  always_comb begin
    diff_c          = (TEMP_W+1)'(sense.room_temp) - (TEMP_W+1)'(sense.coil_temp);
    float_open_next = float_open_reg;
    sens_bad_next   = sens_bad_reg;
    low_diff_next   = low_diff_reg;
    if (tick_next) begin                                                // R12
      float_open_next = !ctrl.float_closed;                             // R2
      sens_bad_next   = res_bad(sense.room_res) || res_bad(sense.coil_res)
                        || res_bad(sense.outdoor_temp_sensor);          // R4
      low_diff_next   = diff_c < MIN_DIFF_C;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      float_open_reg <= 1'b0;
      sens_bad_reg   <= 1'b0;
      low_diff_reg   <= 1'b0;
    end else begin
      float_open_reg <= float_open_next;
      sens_bad_reg   <= sens_bad_next;
      low_diff_reg   <= low_diff_next;
    end
  end

  // ---------------------------------------------------------------
  // duration counters
  // ---------------------------------------------------------------
  logic [6:0]  float_sec_reg, float_sec_next;
  logic [10:0] run_sec_reg,   run_sec_next;
  logic [5:0]  low_sec_reg,   low_sec_next;
  logic [1:0]  low_hits_reg,  low_hits_next;
  logic        running;
  logic        float_trip;
  logic        cool_trip;
  cfm_alarm_t  alarm_reg,     alarm_next;

  // operation means the compressor is actually being driven
  assign running = compressor_on;

  always_comb begin
    float_sec_next = float_sec_reg;
    run_sec_next   = run_sec_reg;
    low_sec_next   = low_sec_reg;
    low_hits_next  = low_hits_reg;
    float_trip     = 1'b0;
    cool_trip      = 1'b0;
    if (tick_reg) begin
      // any closed sample breaks the run of open seconds
      if (!float_open_reg) begin
        float_sec_next = 7'h0;
      end else if (float_sec_reg == 7'(FLOAT_SEC - 1)) begin
        float_trip     = 1'b1;                                          // R3
        float_sec_next = 7'h0;
      end else begin
        float_sec_next = float_sec_reg + 7'h1;
      end

      // the start-up window restarts each time operation stops
      if (!running) begin
        run_sec_next = 11'h0;
        low_sec_next = 6'h0;
      end else if (run_sec_reg != 11'(STARTUP_SEC)) begin
        run_sec_next = run_sec_reg + 11'h1;
        low_sec_next = 6'h0;
      end else if (!low_diff_reg) begin
        low_sec_next = 6'h0;
      end else if (low_sec_reg == 6'(LOWDIFF_SEC - 1)) begin
        low_sec_next = 6'h0;                                            // R5
        if (low_hits_reg == 2'(LOWDIFF_HITS - 1)) begin
          cool_trip = 1'b1;
        end else begin
          low_hits_next = low_hits_reg + 2'h1;
        end
      end else begin
        low_sec_next = low_sec_reg + 6'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // alarm latch
  // ---------------------------------------------------------------
  // first cause wins; the code then holds until power-on reset       
  always_comb begin
    alarm_next = alarm_reg;
    if (alarm_reg == CFM_ALM_NONE) begin                                // R8
      if (tick_reg && sens_bad_reg) begin
        alarm_next = CFM_ALM_SENSOR;                                    // R4
      end else if (float_trip) begin
        alarm_next = CFM_ALM_OVERFLOW;                                  // R3
      end else if (cool_trip) begin
        alarm_next = CFM_ALM_COOLING;                                   // R5
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      float_sec_reg <= 7'h0;
      run_sec_reg   <= 11'h0;
      low_sec_reg   <= 6'h0;
      low_hits_reg  <= 2'h0;
      alarm_reg     <= CFM_ALM_NONE;
    end else begin
      float_sec_reg <= float_sec_next;
      run_sec_reg   <= run_sec_next;
      low_sec_reg   <= low_sec_next;
      low_hits_reg  <= low_hits_next;
      alarm_reg     <= alarm_next;
    end
  end

  // ---------------------------------------------------------------
  // relay drive
  // ---------------------------------------------------------------
  // no run latch exists: after reset the outputs follow the thermostat
  // again on their own, which gives automatic restart after power loss
  logic comp_reg, comp_next;
  logic fan_reg,  fan_next;
  logic pump_reg;
  logic warn_reg, warn_next;
  logic stop;

  always_comb begin
    stop      = float_open_reg || (alarm_next != CFM_ALM_NONE);         // R2 R6
    comp_next = ctrl.cool_req && ctrl.fan_req && !stop;                 // R11 R10
    fan_next  = ctrl.fan_req && !stop;                                  // R10
    warn_next = alarm_next != CFM_ALM_NONE;                             // R7
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      comp_reg <= 1'b0;
      fan_reg  <= 1'b0;
      pump_reg <= 1'b0;
      warn_reg <= 1'b0;
    end else begin
      comp_reg <= comp_next;
      fan_reg  <= fan_next;
      pump_reg <= comp_next;                                            // R1
      warn_reg <= warn_next;
    end
  end

  // ---------------------------------------------------------------
  // buzzer
  // ---------------------------------------------------------------
  cfm_buzzer #(
    .BEEP_LEN  (BEEP_LEN),
    .PAUSE_LEN (PAUSE_LEN)
  ) u_buzzer (
    .clk      (clk),
    .rst_b    (rst_b),
    .alarm    (alarm_reg),                                              // R6
    .sound_en (ctrl.buzzer_config_switch),                              // R9
    .buzzer   (buzzer)
  );

  assign compressor_on = comp_reg;
  assign drain_pump_on = pump_reg;
  assign fan_on        = fan_reg;
  assign warn_relay    = warn_reg;
  assign alarm_code    = alarm_reg;

endmodule : cfm_monitor
`default_nettype wire

//--- verification/cfm_plant_model.sv
// plant side model: thermistor converter and room/coil temperatures
// assumes the bench sets its controls; values change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module cfm_plant_model
  import cfm_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rnd_en,
  input  wire logic [1:0]               bad_idx,
  input  wire logic [RES_W-1:0]         bad_val,
  input  wire logic signed [TEMP_W-1:0] room_t,
  input  wire logic signed [TEMP_W-1:0] coil_t,
  output var  cfm_sense_t               sense
);
  logic [RES_W-1:0] res_q [3];
  // random readings stay inside the healthy band so only bad_idx can fault
  always @(negedge clk) begin
    for (int i = 0; i < 3; i++) begin
      res_q[i] = rnd_en ? RES_W'($urandom_range(RES_HIGH_LIM - 1, RES_LOW_LIM + 1)) : 16'h0A00;
      if (bad_idx == 2'(i)) res_q[i] = bad_val;
    end
    sense <= '{res_q[0], res_q[1], res_q[2], room_t, coil_t};
  end
endmodule : cfm_plant_model
`default_nettype wire

//--- verification/cfm_monitor_properties.sv
// port-level checks of the fault monitor
// assumes binding onto cfm_monitor with its TICK_LEN
`timescale 1ns/1ns
`default_nettype none
module cfm_monitor_checker
  import cfm_pkg::*;
#(parameter int TICK_LEN = 10) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire cfm_ctrl_t  ctrl,
  input wire cfm_sense_t sense,
  input wire logic       compressor_on,
  input wire logic       drain_pump_on,
  input wire logic       fan_on,
  input wire logic       warn_relay,
  input wire logic       buzzer,
  input wire cfm_alarm_t alarm_code
);
  localparam int SENS_WIN = TICK_LEN + 3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  int   open_cnt;
  logic bad_res;
  assign bad_res = sense.room_res < RES_LOW_LIM || sense.room_res > RES_HIGH_LIM ||
                   sense.coil_res < RES_LOW_LIM || sense.coil_res > RES_HIGH_LIM ||
                   sense.outdoor_temp_sensor < RES_LOW_LIM || sense.outdoor_temp_sensor > RES_HIGH_LIM;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) open_cnt <= 0;
    else open_cnt <= ctrl.float_closed ? 0 : open_cnt + 1;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_PUMP_FOLLOWS: assert property (drain_pump_on == compressor_on)
    else $error("pump differs from compressor");
  AST_COMP_NEEDS_REQ: assert property (compressor_on
    |-> $past(ctrl.cool_req) && $past(ctrl.fan_req) && fan_on)
    else $error("compressor without both requests");
  AST_FLOAT_HALTS: assert property (open_cnt > TICK_LEN + 1 |-> !compressor_on && !fan_on)
    else $error("unit runs with pan full");
  AST_OVERFLOW_NEEDS_OPEN: assert property ($changed(alarm_code) && alarm_code == CFM_ALM_OVERFLOW
    |-> open_cnt >= (FLOAT_SEC - 1) * TICK_LEN)
    else $error("overflow alarm too early");
  AST_SENSOR_RAISES: assert property (bad_res && alarm_code == CFM_ALM_NONE
    |-> ##[1:SENS_WIN] alarm_code != CFM_ALM_NONE)
    else $error("bad sensor not alarmed");
  AST_ALARM_STOPS: assert property (alarm_code != CFM_ALM_NONE |-> !compressor_on && !fan_on)
    else $error("alarm did not stop unit");
  AST_QUIET_IDLE: assert property (alarm_code == CFM_ALM_NONE |-> !buzzer)
    else $error("buzzer without alarm");
  AST_WARN_RELAY: assert property (warn_relay == (alarm_code != CFM_ALM_NONE))
    else $error("warning relay mismatch");
  AST_ALARM_LATCHED: assert property (alarm_code != CFM_ALM_NONE |=> $stable(alarm_code))
    else $error("alarm changed after latch");
  AST_SWITCH_SILENCES: assert property (!ctrl.buzzer_config_switch |=> !buzzer)
    else $error("buzzer sounds while silenced");
  COV_SENSOR: cover property (alarm_code == CFM_ALM_SENSOR && buzzer);
  COV_OVERFLOW: cover property (alarm_code == CFM_ALM_OVERFLOW && buzzer);
  COV_COOLING: cover property (alarm_code == CFM_ALM_COOLING && buzzer);
endmodule : cfm_monitor_checker
`default_nettype wire

//--- verification/cfm_monitor_tb_top.sv
// self-checking bench for the fault monitor with a plant model
// assumes short timebase parameters so long counts finish quickly
`timescale 1ns/1ns
`default_nettype none
module cfm_monitor_tb_top
  import cfm_pkg::*;
;
  localparam int TK = 10;
  logic                     clk, rst_b, rnd_en, drain_pump_on;
  logic                     compressor_on, fan_on, warn_relay, buzzer;
  logic [1:0]               bad_idx;
  logic [RES_W-1:0]         bad_val;
  logic signed [TEMP_W-1:0] room_t, coil_t;
  cfm_ctrl_t                ctrl;
  cfm_sense_t               sense;
  cfm_alarm_t               alarm_code, prev_code;
  cfm_alarm_t               exp_q [$];
  int                       fail_count, checks_done, cycles, seed_v;
  logic                     c, f;
  cfm_monitor #(.TICK_LEN(TK), .BEEP_LEN(3), .PAUSE_LEN(8)) u_cfm_monitor (.clk(clk), .rst_b(rst_b),
    .ctrl(ctrl), .sense(sense), .compressor_on(compressor_on), .drain_pump_on(drain_pump_on),
    .fan_on(fan_on), .warn_relay(warn_relay), .buzzer(buzzer), .alarm_code(alarm_code));
  cfm_plant_model u_cfm_plant_model (.clk(clk), .rnd_en(rnd_en), .bad_idx(bad_idx), .bad_val(bad_val),
    .room_t(room_t), .coil_t(coil_t), .sense(sense));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
  endtask : do_reset
  // bounded wait, then one more edge so the scoreboard has popped
  task automatic wait_alarm(input int n);
    for (int i = 0; i < n && alarm_code === CFM_ALM_NONE; i++) @(negedge clk);
    @(negedge clk);
    check("queue", 16'(exp_q.size()), 16'h0);
  endtask : wait_alarm
  // a window of one whole pattern period holds exactly n rises
  task automatic beeps(input int n, input int exp);
    int   r;
    logic p;
    r = 0;
    p = buzzer;
    repeat (6 * n + 9) begin
      @(negedge clk);
      if (buzzer && !p) r++;
      p = buzzer;
    end
    check("beeps", 16'(r), 16'(exp));
  endtask : beeps
  // ----------------------------------------
  // scoreboard
  // ----------------------------------------
  always @(negedge clk) begin
    if (alarm_code !== prev_code && alarm_code !== CFM_ALM_NONE) begin
      if (exp_q.size() == 0) check("unexpected", 16'(alarm_code), 16'(CFM_ALM_NONE));
      else check("alarm", 16'(alarm_code), 16'(exp_q.pop_front()));
      check("warn", 16'(warn_relay), 16'h1);
    end
    prev_code <= alarm_code;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    seed_v = $urandom(32'h11E2);
    ctrl = '{1'b1, 1'b1, 1'b1, 1'b1};
    {rnd_en, bad_idx, bad_val, room_t, coil_t} = {1'b0, 2'h3, 16'h0A00, 8'sh19, 8'sh0A};
    do_reset();
    repeat (2) @(negedge clk);
    check("resume", 16'(compressor_on), 16'h1);
    rnd_en = 1'b1;
    repeat (200) begin
      {c, f} = 2'($urandom);
      ctrl.cool_req = c;
      ctrl.fan_req = f;
      @(negedge clk);
      check("comp", 16'(compressor_on), 16'(c & f));
      check("fan", 16'(fan_on), 16'(f));
      check("pump", 16'(drain_pump_on), 16'(c & f));
    end
    rnd_en = 1'b0;
    for (int s = 0; s < 3; s++) for (int h = 0; h < 2; h++) begin
      ctrl = '{1'b1, 1'b1, 1'b1, h[0]};
      bad_idx = 2'h3;
      do_reset();
      bad_idx = 2'(s);
      bad_val = h ? RES_HIGH_LIM : RES_LOW_LIM;
      repeat (3 * TK) @(negedge clk);
      check("limit", 16'(alarm_code), 16'(CFM_ALM_NONE));
      exp_q.push_back(CFM_ALM_SENSOR);
      bad_val = h ? RES_HIGH_LIM + 16'h0001 : RES_LOW_LIM - 16'h0001;
      wait_alarm(3 * TK);
      bad_idx = 2'h3;
      repeat (3 * TK) @(negedge clk);
      check("stopped", 16'(compressor_on), 16'h0);
      check("latched", 16'(alarm_code), 16'(CFM_ALM_SENSOR));
      beeps(1, h);
    end
    do_reset();
    ctrl.float_closed = 1'b0;
    repeat (2 * TK + 2) @(negedge clk);
    check("halt", 16'(compressor_on), 16'h0);
    repeat (50 * TK) @(negedge clk);
    ctrl.float_closed = 1'b1;
    repeat (2 * TK + 2) @(negedge clk);
    check("rerun", 16'(compressor_on), 16'h1);
    ctrl.float_closed = 1'b0;
    repeat (58 * TK) @(negedge clk);
    check("early", 16'(alarm_code), 16'(CFM_ALM_NONE));
    exp_q.push_back(CFM_ALM_OVERFLOW);
    wait_alarm(5 * TK);
    beeps(2, 2);
    ctrl.float_closed = 1'b1;
    for (int d = 5; d >= 4; d--) begin
      do_reset();
      coil_t = 8'(25 - d);
      repeat (1370 * TK) @(negedge clk);
      check("cool", 16'(alarm_code), 16'(CFM_ALM_NONE));
      if (d == 4) exp_q.push_back(CFM_ALM_COOLING);
      wait_alarm(30 * TK);
      check("cool_end", 16'(alarm_code), 16'(d == 4 ? CFM_ALM_COOLING : CFM_ALM_NONE));
    end
    beeps(3, 3);
    final_report();
  end
endmodule : cfm_monitor_tb_top
bind cfm_monitor cfm_monitor_checker #(.TICK_LEN(TICK_LEN)) u_cfm_monitor_checker (.clk(clk), .rst_b(rst_b),
  .ctrl(ctrl), .sense(sense), .compressor_on(compressor_on), .drain_pump_on(drain_pump_on),
  .fan_on(fan_on), .warn_relay(warn_relay), .buzzer(buzzer), .alarm_code(alarm_code));
`default_nettype wire
